// [viu_pkg.sv]
// Purpose: shared constants and types of the vectored interrupt unit
// Assumes: 32-bit classic Wishbone register access, byte addresses below
// Notes:   slot registers repeat every word from their base offset
package viu_pkg;
   localparam int NUM_SRC   = 32;
   localparam int NUM_SLOTS = 16;
   localparam int SRC_W     = 5;
   localparam int ADR_W     = 12;

   localparam logic [11:0] OFS_RAW_STATUS  = 12'h000;
   localparam logic [11:0] OFS_FAST_STATUS = 12'h004;
   localparam logic [11:0] OFS_NORM_STATUS = 12'h008;
   localparam logic [11:0] OFS_CLASS_SEL   = 12'h00C;
   localparam logic [11:0] OFS_ENABLE      = 12'h010;
   localparam logic [11:0] OFS_VECT_ADDR   = 12'h014;
   localparam logic [11:0] OFS_DEF_ADDR    = 12'h018;
   localparam logic [11:0] OFS_EVT_STATUS  = 12'h01C;
   localparam logic [11:0] OFS_EVT_MASK    = 12'h020;
   localparam logic [11:0] OFS_SLOT_ADDR   = 12'h100;
   localparam logic [11:0] OFS_SLOT_CTRL   = 12'h200;

   localparam int SLOT_EN_BIT  = 5;
   localparam int EVT_FAST_BIT = 0;
   localparam int EVT_NORM_BIT = 1;
   localparam int EVT_W        = 2;

   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [31:0] RST_DEF_ADDR = 32'h0000_0000;

   typedef struct packed {
      logic             en;
      logic [SRC_W-1:0] src;
   } viu_slot_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } viu_wb_req_type;
endpackage

// [viu_top.sv]
// Purpose: vectored interrupt unit with fast, vectored and plain normal classes
// Assumes: request lines are active-high levels synchronous to clk_i
// Notes:   Wishbone classic slave, ack one cycle after the request is seen
// Function
// - every request line is classed fast, vectored normal or plain normal by software.
// - fast requests outrank every normal request, vectored or not.
// - all fast-class pending requests merge into one fast output.
// - a readable word shows which fast-class sources are requesting.
// - sixteen vectored slots, any request line may go to any slot.
// - slot zero has highest priority, falling strictly to slot fifteen.
// - plain normal requests rank below vectored and fast requests.
// - all pending normal requests merge into one normal output.
// - vector register returns routine address of best pending vectored slot.
// - with no vectored request pending, vector register returns the default address.
// - a readable word shows which normal requests are active.
// - each peripheral drives exactly one, possibly merged, request line.
// - class and slot changes take effect on the very next evaluation.
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module viu_top #(
   parameter int NUM_SRC   = viu_pkg::NUM_SRC,
   parameter int NUM_SLOTS = viu_pkg::NUM_SLOTS
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [NUM_SRC-1:0] irq_req_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [11:0]        wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   output logic                    fast_interrupt_request_o,
   output logic                    normal_irq_o,
   output logic                    evt_irq_o
);
   function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [3:0] first_set(input logic [NUM_SLOTS-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   viu_pkg::viu_wb_req_type wb;
   assign wb = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   // configuration state
   logic [NUM_SRC-1:0]         class_sel,   next_class_sel;
   logic [NUM_SRC-1:0]         enable,      next_enable;
   logic [31:0]                def_addr,    next_def_addr;
   logic [viu_pkg::EVT_W-1:0]  evt_status,  next_evt_status;
   logic [viu_pkg::EVT_W-1:0]  evt_mask,    next_evt_mask;
   logic [31:0]                slot_addr      [NUM_SLOTS];
   logic [31:0]                next_slot_addr [NUM_SLOTS];
   viu_pkg::viu_slot_type      slot_cfg       [NUM_SLOTS];
   viu_pkg::viu_slot_type      next_slot_cfg  [NUM_SLOTS];

   // datapath state
   logic [NUM_SRC-1:0]   req_q;
   logic [NUM_SRC-1:0]   pending;
   logic [NUM_SRC-1:0]   fast_pend;
   logic [NUM_SRC-1:0]   norm_pend;
   logic [NUM_SLOTS-1:0] slot_hit;
   logic                 slot_any;
   logic [3:0]           slot_win;
   logic [31:0]          vect_addr,  next_vect_addr;
   logic                 next_fiq;
   logic                 next_irq;
   logic                 next_evt_irq;
   logic                 next_ack;
   logic [31:0]          next_dat;
   logic                 wr_strobe;
   localparam int EVT_W_L = viu_pkg::EVT_W;
   logic [EVT_W_L-1:0]   evt_set;

   // request lines are sampled levels, one line per peripheral
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_q <= '0;
      end else begin
         req_q <= irq_req_i;
      end
   end

   // classification and priority resolution, purely from current settings
   always_comb begin
      pending   = req_q & enable;
      fast_pend = pending & class_sel;
      norm_pend = pending & ~class_sel;
      for (int n = 0; n < NUM_SLOTS; n++) begin
         slot_hit[n] = slot_cfg[n].en & norm_pend[slot_cfg[n].src];
      end
      slot_any       = |slot_hit;
      slot_win       = first_set(slot_hit);
      next_vect_addr = slot_any ? slot_addr[slot_win] : def_addr;
      next_fiq       = |fast_pend;
      next_irq       = |norm_pend;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vect_addr                <= viu_pkg::RST_DEF_ADDR;
         fast_interrupt_request_o <= 1'b0;
         normal_irq_o             <= 1'b0;
      end else begin
         vect_addr                <= next_vect_addr;
         fast_interrupt_request_o <= next_fiq;
         normal_irq_o             <= next_irq;
      end
   end

   // register bus: request seen, ack and read data one cycle later, write on the ack edge
   always_comb begin
      next_ack  = wb.cyc & wb.stb & ~wb_ack_o;
      wr_strobe = wb.cyc & wb.stb & wb.we & wb_ack_o;
      next_dat  = 32'h0000_0000;
      if (wb.adr[11:8] == viu_pkg::OFS_SLOT_ADDR[11:8] && wb.adr[7:2] < 6'(NUM_SLOTS)) begin
         next_dat = slot_addr[wb.adr[5:2]];
      end else if (wb.adr[11:8] == viu_pkg::OFS_SLOT_CTRL[11:8] && wb.adr[7:2] < 6'(NUM_SLOTS)) begin
         next_dat = 32'(slot_cfg[wb.adr[5:2]]);
      end else begin
         unique case (wb.adr)
            viu_pkg::OFS_RAW_STATUS:  next_dat = 32'(req_q);
            viu_pkg::OFS_FAST_STATUS: next_dat = 32'(fast_pend);
            viu_pkg::OFS_NORM_STATUS: next_dat = 32'(norm_pend);
            viu_pkg::OFS_CLASS_SEL:   next_dat = 32'(class_sel);
            viu_pkg::OFS_ENABLE:      next_dat = 32'(enable);
            viu_pkg::OFS_VECT_ADDR:   next_dat = vect_addr;
            viu_pkg::OFS_DEF_ADDR:    next_dat = def_addr;
            viu_pkg::OFS_EVT_STATUS:  next_dat = 32'(evt_status);
            viu_pkg::OFS_EVT_MASK:    next_dat = 32'(evt_mask);
            default:                  next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= viu_pkg::RST_WORD;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_ack ? next_dat : wb_dat_o;
      end
   end

   // configuration writes; events set on rising fast/normal outputs, set wins over clear
   always_comb begin
      logic [31:0] tmp;
      tmp             = 32'h0000_0000;
      next_class_sel  = class_sel;
      next_enable     = enable;
      next_def_addr   = def_addr;
      next_evt_mask   = evt_mask;
      next_evt_status = evt_status;
      next_slot_addr  = slot_addr;
      next_slot_cfg   = slot_cfg;
      if (wr_strobe) begin
         if (wb.adr[11:8] == viu_pkg::OFS_SLOT_ADDR[11:8] && wb.adr[7:2] < 6'(NUM_SLOTS)) begin
            next_slot_addr[wb.adr[5:2]] = wr_merge(slot_addr[wb.adr[5:2]], wb.dat, wb.sel);
         end else if (wb.adr[11:8] == viu_pkg::OFS_SLOT_CTRL[11:8] && wb.adr[7:2] < 6'(NUM_SLOTS)) begin
            tmp = wr_merge(32'(slot_cfg[wb.adr[5:2]]), wb.dat, wb.sel);
            next_slot_cfg[wb.adr[5:2]] = viu_pkg::viu_slot_type'(tmp[viu_pkg::SLOT_EN_BIT:0]);
         end else begin
            unique case (wb.adr)
               viu_pkg::OFS_CLASS_SEL: begin
                  tmp            = wr_merge(32'(class_sel), wb.dat, wb.sel);
                  next_class_sel = tmp[NUM_SRC-1:0];
               end
               viu_pkg::OFS_ENABLE: begin
                  tmp         = wr_merge(32'(enable), wb.dat, wb.sel);
                  next_enable = tmp[NUM_SRC-1:0];
               end
               viu_pkg::OFS_DEF_ADDR: begin
                  next_def_addr = wr_merge(def_addr, wb.dat, wb.sel);
               end
               viu_pkg::OFS_EVT_MASK: begin
                  tmp           = wr_merge(32'(evt_mask), wb.dat, wb.sel);
                  next_evt_mask = tmp[EVT_W_L-1:0];
               end
               viu_pkg::OFS_EVT_STATUS: begin
                  if (wb.sel[0]) begin
                     next_evt_status = evt_status & ~wb.dat[EVT_W_L-1:0];
                  end
               end
               default: begin
                  tmp = 32'h0000_0000;
               end
            endcase
         end
      end
      evt_set                             = '0;
      evt_set[viu_pkg::EVT_FAST_BIT]      = next_fiq & ~fast_interrupt_request_o;
      evt_set[viu_pkg::EVT_NORM_BIT]      = next_irq & ~normal_irq_o;
      next_evt_status                     = next_evt_status | evt_set;
      next_evt_irq                        = |(next_evt_status & next_evt_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         class_sel  <= '0;
         enable     <= '0;
         def_addr   <= viu_pkg::RST_DEF_ADDR;
         evt_status <= '0;
         evt_mask   <= '0;
         evt_irq_o  <= 1'b0;
         for (int n = 0; n < NUM_SLOTS; n++) begin
            slot_addr[n] <= viu_pkg::RST_WORD;
            slot_cfg[n]  <= '0;
         end
      end else begin
         class_sel  <= next_class_sel;
         enable     <= next_enable;
         def_addr   <= next_def_addr;
         evt_status <= next_evt_status;
         evt_mask   <= next_evt_mask;
         evt_irq_o  <= next_evt_irq;
         slot_addr  <= next_slot_addr;
         slot_cfg   <= next_slot_cfg;
      end
   end

   chk_class_split: assert property (@(posedge clk_i) disable iff (rst_i)
      (fast_pend | norm_pend) == pending) else $error("pending request lost by classing");
   chk_fast_excl: assert property (@(posedge clk_i) disable iff (rst_i)
      (norm_pend & class_sel) == '0) else $error("fast source seen as normal");
   chk_fiq_merge: assert property (@(posedge clk_i) disable iff (rst_i)
      (|fast_pend) |=> fast_interrupt_request_o) else $error("fast output missing");
   chk_fiq_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|fast_pend) |=> !fast_interrupt_request_o) else $error("fast output without request");
   chk_irq_merge: assert property (@(posedge clk_i) disable iff (rst_i)
      (|norm_pend) |=> normal_irq_o) else $error("normal output missing");
   chk_slot_prio: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_any |-> slot_hit[slot_win] && ((slot_hit & ((16'h0001 << slot_win) - 16'h0001)) == '0))
      else $error("lower slot outranked a higher one");
   chk_vect_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_any |=> vect_addr == $past(slot_addr[slot_win])) else $error("wrong vector address");
   chk_default_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      !slot_any |=> vect_addr == $past(def_addr)) else $error("default address not returned");
   chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
   chk_event_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (evt_status[0] && !wr_strobe) |=> evt_status[0]) else $error("sticky event lost");

   // bus side: one ack per access, read data frozen between accesses
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
      else $error("read data moved without an access");
   chk_fast_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == viu_pkg::OFS_FAST_STATUS)
         |=> wb_dat_o == 32'($past(fast_pend)))
      else $error("fast status read wrong");
   chk_norm_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == viu_pkg::OFS_NORM_STATUS)
         |=> wb_dat_o == 32'($past(norm_pend)))
      else $error("normal status read wrong");
   chk_raw_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == viu_pkg::OFS_RAW_STATUS)
         |=> wb_dat_o == 32'($past(req_q)))
      else $error("raw status read wrong");
   chk_vect_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == viu_pkg::OFS_VECT_ADDR)
         |=> wb_dat_o == $past(vect_addr))
      else $error("vector read wrong");

   // interrupt side: outputs, slot winner and event flags
   chk_irq_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|norm_pend) |=> !normal_irq_o)
      else $error("normal output without request");
   chk_slot_not_fast: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_any |-> !class_sel[slot_cfg[slot_win].src] && enable[slot_cfg[slot_win].src])
      else $error("slot won by a fast or disabled line");
   chk_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (enable == '0) |=> !fast_interrupt_request_o && !normal_irq_o)
      else $error("output from disabled lines");
   chk_vect_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_any |=> normal_irq_o)
      else $error("vectored request without normal output");
   chk_evt_level: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_irq_o == |(evt_status & evt_mask))
      else $error("event output disagrees with status");
   chk_evt_fast_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (next_fiq && !fast_interrupt_request_o) |=> evt_status[viu_pkg::EVT_FAST_BIT])
      else $error("fast event not set");
   chk_evt_norm_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (next_irq && !normal_irq_o) |=> evt_status[viu_pkg::EVT_NORM_BIT])
      else $error("normal event not set");
endmodule

// [viu_src_model.sv]
// Purpose: peripheral side model, one merged request line per peripheral
// Assumes: flags are driven by the bench at the rising edge
// Notes:   two internal flags per peripheral merge onto its single line
`timescale 1ns/1ps
module viu_src_model #(
   parameter int NUM_SRC = 32
) (
   input  wire logic               clk_i,
   input  wire logic [NUM_SRC-1:0] flag_a_i,
   input  wire logic [NUM_SRC-1:0] flag_b_i,
   output logic      [NUM_SRC-1:0] irq_req_o
);
   // level request, held while any flag of the peripheral is set
   always_ff @(posedge clk_i) begin
      irq_req_o <= flag_a_i | flag_b_i;
   end
endmodule

// [tb.sv]
// Purpose: self-checking bench of the vectored interrupt unit
// Assumes: classic Wishbone master, requests from the peripheral model
// Notes:   outputs are levels, read after a few cycles of settling
`timescale 1ns/1ps
module tb;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic [3:0]  sel = 4'h0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0000_0000, rdat, fa = 32'h0000_0000, fb = 32'h0000_0000;
   logic [31:0] req, dat_o;
   logic        ack, fast_interrupt_request, nirq, eirq;
   int          errors = 0, total_checks = 0;
   always #50 clk = ~clk;
   viu_src_model i_viu_src_model (.clk_i(clk), .flag_a_i(fa), .flag_b_i(fb), .irq_req_o(req));
   viu_top i_viu_top (.clk_i(clk), .rst_i(rst), .irq_req_i(req), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .fast_interrupt_request_o(fast_interrupt_request), .normal_irq_o(nirq), .evt_irq_o(eirq));
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk("ack", 32'h0000_0001, 32'h0000_0000);
      rdat = dat_o;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] exp, string nm);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rdat);
   endtask
   task automatic settle();
      repeat (5) @(posedge clk);
   endtask
   task automatic t_reset();
      rd(viu_pkg::OFS_CLASS_SEL, 32'h0000_0000, "class_sel");
      rd(viu_pkg::OFS_ENABLE, 32'h0000_0000, "enable");
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_0000, "vect_rst");
      rd(12'h0FC, 32'h0000_0000, "unmapped");
      chk("fast_rst", 32'h0000_0000, fast_interrupt_request);
   endtask
   task automatic t_fast();
      wb(1'b1, viu_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
      wb(1'b1, viu_pkg::OFS_CLASS_SEL, 32'h0000_0088);
      fa <= 32'h0010_0008;
      settle();
      chk("fast_one", 32'h0000_0001, fast_interrupt_request);
      chk("norm_one", 32'h0000_0001, nirq);
      rd(viu_pkg::OFS_FAST_STATUS, 32'h0000_0008, "fast_stat");
      rd(viu_pkg::OFS_NORM_STATUS, 32'h0010_0000, "norm_stat");
      fa <= 32'h0000_0000;
      fb <= 32'h0000_0080;
      settle();
      chk("fast_other", 32'h0000_0001, fast_interrupt_request);
      rd(viu_pkg::OFS_FAST_STATUS, 32'h0000_0080, "fast_stat2");
      fb <= 32'h0000_0000;
      settle();
      chk("fast_off", 32'h0000_0000, fast_interrupt_request);
      chk("norm_off", 32'h0000_0000, nirq);
   endtask
   task automatic t_vect();
      wb(1'b1, viu_pkg::OFS_CLASS_SEL, 32'h0000_0000);
      wb(1'b1, viu_pkg::OFS_DEF_ADDR, 32'h0000_1000);
      wb(1'b1, viu_pkg::OFS_SLOT_ADDR, 32'h0000_2000);
      wb(1'b1, viu_pkg::OFS_SLOT_CTRL, 32'h0000_0029);
      wb(1'b1, viu_pkg::OFS_SLOT_ADDR + 12'h03C, 32'h0000_3F00);
      wb(1'b1, viu_pkg::OFS_SLOT_CTRL + 12'h03C, 32'h0000_0022);
      fa <= 32'h0010_0000;
      settle();
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_1000, "vect_def");
      fa <= 32'h0010_0004;
      settle();
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_3F00, "vect_s15");
      fa <= 32'h0010_0204;
      settle();
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_2000, "vect_s0");
      chk("norm_vec", 32'h0000_0001, nirq);
      wb(1'b1, viu_pkg::OFS_CLASS_SEL, 32'h0000_0200);
      settle();
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_3F00, "vect_recl");
      chk("fast_recl", 32'h0000_0001, fast_interrupt_request);
      fa <= 32'h0000_0000;
      settle();
   endtask
   task automatic t_cfg();
      wb(1'b1, viu_pkg::OFS_ENABLE, 32'hFFFF_FDFF);
      fa <= 32'h0000_0204;
      settle();
      rd(viu_pkg::OFS_RAW_STATUS, 32'h0000_0204, "raw_stat");
      chk("fast_gate", 32'h0000_0000, fast_interrupt_request);
      chk("norm_gate", 32'h0000_0001, nirq);
      rd(viu_pkg::OFS_VECT_ADDR, 32'h0000_3F00, "vect_gate");
      rd(viu_pkg::OFS_SLOT_CTRL + 12'h03C, 32'h0000_0022, "slot_ctrl");
      rd(viu_pkg::OFS_DEF_ADDR, 32'h0000_1000, "def_addr");
      fa <= 32'h0000_0000;
      wb(1'b1, viu_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
      settle();
   endtask
   task automatic t_evt();
      wb(1'b1, viu_pkg::OFS_EVT_MASK, 32'h0000_0001);
      wb(1'b1, viu_pkg::OFS_EVT_STATUS, 32'h0000_0003);
      settle();
      chk("evt_clr", 32'h0000_0000, eirq);
      fa <= 32'h0000_0200;
      settle();
      chk("evt_set", 32'h0000_0001, eirq);
      rd(viu_pkg::OFS_EVT_STATUS, 32'h0000_0001, "evt_stat");
      wb(1'b1, viu_pkg::OFS_EVT_MASK, 32'h0000_0000);
      settle();
      chk("evt_mask", 32'h0000_0000, eirq);
      wb(1'b1, viu_pkg::OFS_EVT_MASK, 32'h0000_0001);
      wb(1'b1, viu_pkg::OFS_EVT_STATUS, 32'h0000_0001);
      settle();
      chk("evt_w1c", 32'h0000_0000, eirq);
      fa <= 32'h0000_0000;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      t_reset();
      t_fast();
      t_vect();
      t_cfg();
      t_evt();
      results();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      results();
   end
endmodule
